// ===== verilog/rss_pkg.sv
// Shared constants for the reset source sequencer and its host controller.
package rss_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned POR_TIME_MS = 22;
    localparam int unsigned WAKE_TIME_MS = 2;
    localparam int unsigned SOFT_TIME_US = 2;
    localparam int unsigned PHY_TIME_US = 100;
    localparam int unsigned PHY_BASIC_TIME_US = 100;
    localparam int unsigned HOST_TIMEOUT_MS = 100;
    // Cycle counts derived from the clock rate, except the EEPROM probe count, which is fixed at 64.
    localparam int unsigned POR_CYCLES = POR_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_CYCLES = WAKE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFT_CYCLES = SOFT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PHY_CYCLES = PHY_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PHY_BASIC_CYCLES = PHY_BASIC_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOST_TIMEOUT_CYCLES = HOST_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned EEPROM_PROBE_CYCLES = 64;
    // Device register indices.
    localparam logic [2:0] DEV_HARDWARE_CONFIG = 3'h0;
    localparam logic [2:0] DEV_POWER_MGMT_CONTROL = 3'h1;
    localparam logic [2:0] DEV_WAKE_TEST = 3'h2;
    localparam logic [2:0] DEV_EEPROM_CMD = 3'h3;
    localparam logic [2:0] DEV_PHY_BASIC = 3'h4;
    localparam logic [2:0] DEV_PHY_STATUS = 3'h5;
    // Field positions.
    localparam int unsigned SOFT_RST_BIT = 0;
    localparam int unsigned READY_BIT = 0;
    localparam int unsigned PHY_RST_BIT = 10;
    localparam int unsigned PHY_BASIC_RST_BIT = 15;
    localparam int unsigned EEPROM_BUSY_BIT = 31;
    localparam int unsigned LINK_UP_BIT = 2;
    localparam int unsigned PM_MODE_LSB = 12;
    // Host controller Avalon word addresses (byte address = 4 * index).
    localparam logic [3:0] HC_CMD = 4'h0;
    localparam logic [3:0] HC_STATUS = 4'h1;
    localparam logic [3:0] HC_RDATA = 4'h2;
    localparam logic [3:0] HC_WDATA = 4'h3;
    localparam logic [3:0] HC_ADDR = 4'h4;
    // Host command codes.
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h1;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] CMD_WAIT_READY = 3'h3;
    localparam logic [2:0] CMD_WAIT_EEPROM = 3'h4;
    localparam logic [2:0] CMD_WAIT_LINK = 3'h5;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ===== verilog/rss_link_if.sv
// Interface joining the sequencer device and its host controller.
`timescale 1ns/1ps
interface rss_link_if;
    logic hw_reset_pin_n;
    logic req;
    logic wr;
    logic [2:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    modport device (
        input hw_reset_pin_n, req, wr, addr, wdata,
        output rdata, ack
    );
    modport host (
        output hw_reset_pin_n, req, wr, addr, wdata,
        input rdata, ack
    );
endinterface

// ===== verilog/rss_device.sv
// Reset source sequencer: combines reset sources, times them and reports readiness.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Five reset sources feed the sequencer.
// - Power loss or first power starts reset.
// - Power-on reset lasts about 22 ms.
// - Ready reads zero until power-on completes.
// - Pin low resets; ready follows completion.
// - Host holds reset pin low long enough.
// - Wake write sets ready within 2 ms.
// - Soft reset bit self-clears after 2 us.
// - Soft reset keeps preserved bits, bus logic.
// - PHY reset bit self-clears after 100 us.
// - PHY basic reset bit self-clears when done.
// - Power-on resets everything, reloads MAC address.
// - Chip resets probe EEPROM while busy set.
// - Host waits EEPROM busy clear first.
// - Host waits link up after PHY reset.
// - Host treats 100 ms not-ready as error.
// - Host only reads while not ready; the host still issues the write and only sets write_blocked.
module rss_device #(
    parameter int unsigned POR_COUNT = rss_pkg::POR_CYCLES,
    parameter int unsigned WAKE_COUNT = rss_pkg::WAKE_CYCLES,
    parameter int unsigned SOFT_COUNT = rss_pkg::SOFT_CYCLES,
    parameter int unsigned PHY_COUNT = rss_pkg::PHY_CYCLES,
    parameter int unsigned PHY_BASIC_COUNT = rss_pkg::PHY_BASIC_CYCLES,
    parameter int unsigned PROBE_COUNT = rss_pkg::EEPROM_PROBE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    rss_link_if.device link,
    input wire logic eeprom_present_i,
    input wire logic phy_link_i,
    output logic chip_reset_o,
    output logic phy_reset_o,
    output logic mac_addr_reload_o,
    output logic [31:0] kept_across_soft_reset_o,
    output logic [31:0] soft_cleared_o
);
    import rss_pkg::*;

    typedef enum logic [4:0] {
        RSS_IDLE = 5'b00001,
        RSS_POR = 5'b00010,
        RSS_SOFT = 5'b00100,
        RSS_WAKE = 5'b01000,
        RSS_PROBE = 5'b10000
    } rss_state_t;

    rss_state_t state;
    logic [31:0] timer;
    logic [31:0] phy_timer;
    logic phy_basic_busy;
    logic ready;
    logic eeprom_busy;
    logic soft_bit;
    logic phy_rst_bit;
    logic [1:0] pm_mode;
    logic pin_s1, pin_s2, link_s1, link_s2, ee_s1, ee_s2;
    logic wr_hit;

    // Pins from outside pass two flip-flops first.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            ee_s1 <= 1'b0;
            ee_s2 <= 1'b0;
        end else begin
            pin_s1 <= link.hw_reset_pin_n;
            pin_s2 <= pin_s1;
            link_s1 <= phy_link_i;
            link_s2 <= link_s1;
            ee_s1 <= eeprom_present_i;
            ee_s2 <= ee_s1;
        end
    end

    assign wr_hit = link.req && link.wr;

    // power cycle restarts
    // The asynchronous reset input stands for power loss, so every power-up starts the timer.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RSS_POR;
            timer <= 32'h0000_0000;
        end else begin
            unique case (state)
                RSS_POR: begin
                    if (!pin_s2) begin
                        timer <= 32'h0000_0000;
                    end else if (timer >= POR_COUNT - 1) begin
                        timer <= 32'h0000_0000;
                        state <= RSS_PROBE;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                RSS_SOFT: begin
                    if (!pin_s2) begin
                        state <= RSS_POR;
                        timer <= 32'h0000_0000;
                    end else if (timer >= SOFT_COUNT - 1) begin
                        timer <= 32'h0000_0000;
                        state <= RSS_PROBE;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                RSS_WAKE: begin
                    if (!pin_s2) begin
                        state <= RSS_POR;
                        timer <= 32'h0000_0000;
                    end else if (timer >= WAKE_COUNT - 1) begin
                        timer <= 32'h0000_0000;
                        state <= RSS_IDLE;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                RSS_PROBE: begin
                    if (!pin_s2) begin
                        state <= RSS_POR;
                        timer <= 32'h0000_0000;
                    end else if (timer >= PROBE_COUNT - 1 || !ee_s2) begin
                        timer <= 32'h0000_0000;
                        state <= RSS_IDLE;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                RSS_IDLE: begin
                    if (!pin_s2) begin
                        state <= RSS_POR;
                        timer <= 32'h0000_0000;
                    end else if (wr_hit && link.addr == DEV_HARDWARE_CONFIG && link.wdata[SOFT_RST_BIT]) begin
                        state <= RSS_SOFT;
                        timer <= 32'h0000_0000;
                    end else if (wr_hit && link.addr == DEV_WAKE_TEST && pm_mode != 2'b00) begin
                        state <= RSS_WAKE;
                        timer <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // ready low in sequence
    // The probe still reports ready; only the busy flag guards the EEPROM.
    assign ready = (state == RSS_IDLE || state == RSS_PROBE) && pm_mode == 2'b00;
    assign eeprom_busy = (state == RSS_PROBE) || (state == RSS_POR) || (state == RSS_SOFT);
    assign soft_bit = (state == RSS_SOFT);

    assign chip_reset_o = (state == RSS_POR);
    assign mac_addr_reload_o = (state == RSS_PROBE);

    // Power mode: a wake write returns to normal operation.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pm_mode <= 2'b00;
        end else if (state == RSS_POR) begin
            pm_mode <= 2'b00;
        end else if (state == RSS_WAKE && timer >= WAKE_COUNT - 1) begin
            pm_mode <= 2'b00;
        end else if (state == RSS_IDLE && wr_hit && link.addr == DEV_POWER_MGMT_CONTROL) begin
            pm_mode <= link.wdata[PM_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_rst_bit <= 1'b0;
            phy_basic_busy <= 1'b0;
            phy_timer <= 32'h0000_0000;
        end else if (state == RSS_POR) begin
            phy_rst_bit <= 1'b0;
            phy_basic_busy <= 1'b0;
            phy_timer <= 32'h0000_0000;
        end else if (phy_rst_bit || phy_basic_busy) begin
            if ((phy_rst_bit && phy_timer >= PHY_COUNT - 1) ||
                (!phy_rst_bit && phy_timer >= PHY_BASIC_COUNT - 1)) begin
                phy_rst_bit <= 1'b0;
                phy_basic_busy <= 1'b0;
                phy_timer <= 32'h0000_0000;
            end else begin
                phy_timer <= phy_timer + 32'h0000_0001;
            end
        end else if (ready && wr_hit && link.addr == DEV_POWER_MGMT_CONTROL && link.wdata[PHY_RST_BIT]) begin
            phy_rst_bit <= 1'b1;
        end else if (ready && wr_hit && link.addr == DEV_PHY_BASIC && link.wdata[PHY_BASIC_RST_BIT]) begin
            phy_basic_busy <= 1'b1;
        end
    end
    assign phy_reset_o = chip_reset_o || phy_rst_bit || phy_basic_busy;

    // preserved bits kept
    // The preserved register clears only on power-on or pin reset.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            kept_across_soft_reset_o <= RESET_WORD;
        end else if (state == RSS_POR) begin
            kept_across_soft_reset_o <= RESET_WORD;
        end else if (ready && wr_hit && link.addr == DEV_HARDWARE_CONFIG) begin
            kept_across_soft_reset_o <= {link.wdata[31:1], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            soft_cleared_o <= RESET_WORD;
        end else if (state == RSS_POR || state == RSS_SOFT) begin
            soft_cleared_o <= RESET_WORD;
        end else if (ready && wr_hit && link.addr == DEV_EEPROM_CMD) begin
            soft_cleared_o <= link.wdata;
        end
    end

    // Reads answer in the cycle of the request; the bus logic is never reset by soft reset.
    always_comb begin
        link.rdata = 32'h0000_0000;
        unique case (link.addr)
            DEV_HARDWARE_CONFIG: link.rdata = {kept_across_soft_reset_o[31:1], soft_bit};
            DEV_POWER_MGMT_CONTROL: begin
                link.rdata[READY_BIT] = ready;
                link.rdata[PHY_RST_BIT] = phy_rst_bit;
                link.rdata[PM_MODE_LSB +: 2] = pm_mode;
            end
            DEV_EEPROM_CMD: link.rdata[EEPROM_BUSY_BIT] = eeprom_busy;
            DEV_PHY_BASIC: link.rdata[PHY_BASIC_RST_BIT] = phy_basic_busy;
            DEV_PHY_STATUS: link.rdata[LINK_UP_BIT] = link_s2 && !phy_reset_o;
            default: link.rdata = 32'h0000_0000;
        endcase
    end
    assign link.ack = link.req;
endmodule // rss_device

// ===== verilog/rss_host.sv
// Host controller: issues device accesses and waits on readiness under Avalon-MM control.
`timescale 1ns/1ps
module rss_host #(
    parameter int unsigned TIMEOUT_COUNT = rss_pkg::HOST_TIMEOUT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    rss_link_if.host link,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic pin_reset_i
);
    import rss_pkg::*;

    typedef enum logic [2:0] {
        RSH_IDLE = 3'b001,
        RSH_ACCESS = 3'b010,
        RSH_POLL = 3'b100
    } rsh_state_t;

    rsh_state_t state;
    logic [2:0] cmd;
    logic [2:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] timer;
    logic busy, done, timeout, write_blocked;
    logic ready_seen;

    assign link.hw_reset_pin_n = !pin_reset_i;
    assign link.req = (state == RSH_ACCESS) || (state == RSH_POLL);
    assign link.wr = (state == RSH_ACCESS) && cmd == CMD_WRITE;
    assign link.addr = (state == RSH_POLL) ?
        (cmd == CMD_WAIT_READY ? DEV_POWER_MGMT_CONTROL : cmd == CMD_WAIT_EEPROM ? DEV_EEPROM_CMD : DEV_PHY_STATUS) : addr;
    assign link.wdata = wdata;
    assign avs_waitrequest_o = 1'b0;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RSH_IDLE;
            cmd <= CMD_NONE;
            addr <= 3'h0;
            wdata <= RESET_WORD;
            rdata <= RESET_WORD;
            timer <= 32'h0000_0000;
            busy <= 1'b0;
            done <= 1'b0;
            timeout <= 1'b0;
            write_blocked <= 1'b0;
            ready_seen <= 1'b0;
        end else begin
            unique case (state)
                RSH_IDLE: begin
                    if (avs_write_i && avs_address_i == HC_ADDR) begin
                        addr <= avs_writedata_i[2:0];
                    end
                    if (avs_write_i && avs_address_i == HC_WDATA) begin
                        wdata <= avs_writedata_i;
                    end
                    if (avs_write_i && avs_address_i == HC_CMD && avs_writedata_i[2:0] != CMD_NONE) begin
                        cmd <= avs_writedata_i[2:0];
                        busy <= 1'b1;
                        done <= 1'b0;
                        timeout <= 1'b0;
                        write_blocked <= 1'b0;
                        timer <= 32'h0000_0000;
                        if (avs_writedata_i[2:0] == CMD_READ || avs_writedata_i[2:0] == CMD_WRITE) begin
                            state <= RSH_ACCESS;
                        end else begin
                            state <= RSH_POLL;
                        end
                    end
                end
                RSH_ACCESS: begin
                    if (cmd == CMD_WRITE && !ready_seen && addr != DEV_WAKE_TEST) begin
                        write_blocked <= 1'b1;
                    end
                    rdata <= link.rdata;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= RSH_IDLE;
                end
                RSH_POLL: begin
                    rdata <= link.rdata;
                    timer <= timer + 32'h0000_0001;
                    if ((cmd == CMD_WAIT_READY && link.rdata[READY_BIT]) ||
                        (cmd == CMD_WAIT_EEPROM && !link.rdata[EEPROM_BUSY_BIT]) ||
                        (cmd == CMD_WAIT_LINK && link.rdata[LINK_UP_BIT])) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= RSH_IDLE;
                    end else if (timer >= TIMEOUT_COUNT - 1) begin
                        busy <= 1'b0;
                        timeout <= 1'b1;
                        state <= RSH_IDLE;
                    end
                end
                default: state <= RSH_IDLE;
            endcase
            if (state == RSH_POLL && cmd == CMD_WAIT_READY) begin
                ready_seen <= link.rdata[READY_BIT];
            end else if (pin_reset_i || (state == RSH_ACCESS && cmd == CMD_WRITE && addr == DEV_WAKE_TEST)) begin
                ready_seen <= 1'b0;
            end
        end
    end

    // pin held by software
    // Software holds pin_reset_i high for the minimum pulse.
    always_comb begin
        unique case (avs_address_i)
            HC_STATUS: avs_readdata_o = {27'h000_0000, ready_seen, write_blocked, timeout, done, busy};
            HC_RDATA: avs_readdata_o = rdata;
            HC_WDATA: avs_readdata_o = wdata;
            HC_ADDR: avs_readdata_o = {29'h0000_0000, addr};
            HC_CMD: avs_readdata_o = {29'h0000_0000, cmd};
            default: avs_readdata_o = 32'h0000_0000;
        endcase
    end
endmodule // rss_host

// ===== dv/rss_props.sv
// Concurrent checks on the link between the reset sequencer and its host controller.
`timescale 1ns/1ps
module rss_props #(
    parameter int unsigned POR_COUNT = 20,
    parameter int unsigned WAKE_COUNT = 10,
    parameter int unsigned SOFT_COUNT = 50,
    parameter int unsigned PHY_COUNT = 40,
    parameter int unsigned PHY_BASIC_COUNT = 40,
    parameter int unsigned PROBE_COUNT = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hw_reset_pin_n,
    input wire logic req,
    input wire logic wr,
    input wire logic [2:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack
);
    import rss_pkg::*;
    // A long stretch with the pin high, no writes and no sleep mode set must end with the device ready.
    localparam int unsigned QUIET = POR_COUNT + WAKE_COUNT + SOFT_COUNT + PROBE_COUNT + 16;
    logic [15:0] por_cnt;
    logic [15:0] quiet_cnt;
    logic [15:0] soft_cnt;
    logic [15:0] phy_cnt;
    logic [15:0] basic_cnt;
    logic [2:0] pin_cnt;
    logic sleeping;
    function automatic logic [15:0] bump(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction
    function automatic logic hit(input logic [2:0] a, input int unsigned b);
        return req && wr && addr == a && wdata[b];
    endfunction
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            por_cnt <= 16'h0000;
            quiet_cnt <= 16'h0000;
            soft_cnt <= 16'hFFFF;
            phy_cnt <= 16'hFFFF;
            basic_cnt <= 16'hFFFF;
        end else begin
            por_cnt <= bump(por_cnt);
            quiet_cnt <= (!hw_reset_pin_n || (req && wr)) ? 16'h0000 : bump(quiet_cnt);
            soft_cnt <= hit(DEV_HARDWARE_CONFIG, SOFT_RST_BIT) ? 16'h0000 : bump(soft_cnt);
            phy_cnt <= hit(DEV_POWER_MGMT_CONTROL, PHY_RST_BIT) ? 16'h0000 : bump(phy_cnt);
            basic_cnt <= hit(DEV_PHY_BASIC, PHY_BASIC_RST_BIT) ? 16'h0000 : bump(basic_cnt);
        end
    end
    // The pin passes a synchroniser first, so the pin check waits a few cycles.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_cnt <= 3'h0;
            sleeping <= 1'b0;
        end else begin
            pin_cnt <= hw_reset_pin_n ? 3'h0 : ((pin_cnt == 3'h7) ? pin_cnt : pin_cnt + 3'h1);
            if (req && wr && addr == DEV_POWER_MGMT_CONTROL) begin
                sleeping <= (wdata[PM_MODE_LSB+1 -: 2] != 2'h0);
            end else if (req && wr && addr == DEV_WAKE_TEST) begin
                sleeping <= 1'b0;
            end
        end
    end
    sequence pmt_read;
        req && !wr && addr == DEV_POWER_MGMT_CONTROL;
    endsequence
    sequence cfg_read;
        req && !wr && addr == DEV_HARDWARE_CONFIG;
    endsequence
    sequence basic_read;
        req && !wr && addr == DEV_PHY_BASIC;
    endsequence
    default clocking dcb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    bus_alive_soft_a: assert property ((soft_cnt < SOFT_COUNT - 1) ##0 cfg_read |-> ack && rdata[SOFT_RST_BIT])
        else $error("bus dead during soft reset");
    por_not_ready_a: assert property ((por_cnt < POR_COUNT) ##0 pmt_read |-> !rdata[READY_BIT])
        else $error("ready set during power-on timing");
    pin_not_ready_a: assert property ((pin_cnt > 3'h4) ##0 pmt_read |-> !rdata[READY_BIT])
        else $error("ready set while reset pin low");
    soft_not_ready_a: assert property ((soft_cnt > 16'h0000 && soft_cnt < SOFT_COUNT - 1) ##0 pmt_read |-> !rdata[READY_BIT])
        else $error("ready set during soft reset");
    ready_returns_a: assert property ((quiet_cnt > QUIET && !sleeping) ##0 pmt_read |-> rdata[READY_BIT])
        else $error("ready still clear after all timers");
    soft_clears_a: assert property ((soft_cnt > SOFT_COUNT + 4) ##0 cfg_read |-> !rdata[SOFT_RST_BIT])
        else $error("soft reset bit did not clear");
    phy_bit_clears_a: assert property ((phy_cnt > PHY_COUNT + 4) ##0 pmt_read |-> !rdata[PHY_RST_BIT])
        else $error("phy reset bit did not clear");
    basic_clears_a: assert property ((basic_cnt > PHY_BASIC_COUNT + 4) ##0 basic_read |-> !rdata[PHY_BASIC_RST_BIT])
        else $error("phy basic reset bit did not clear");
endmodule // rss_props

// ===== dv/test_reset_source_sequencer.sv
// Self-checking bench for the reset sequencer and its host controller.
`timescale 1ns/1ps
module test_reset_source_sequencer;
    import rss_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic phy_link = 1'b0;
    logic eeprom_present = 1'b1;
    localparam int unsigned T_PHY = 40;
    logic pin_reset = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic chip_reset;
    logic phy_reset;
    logic reload;
    logic reload_seen = 1'b0;
    logic [31:0] kept;
    logic [31:0] cleared;
    logic [31:0] r;
    logic [31:0] st;
    int mismatches = 0;
    int num_checks = 0;
    rss_link_if link ();
    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (reload === 1'b1) reload_seen <= 1'b1;
    rss_device #(.POR_COUNT(20), .WAKE_COUNT(10), .SOFT_COUNT(SOFT_CYCLES), .PHY_COUNT(T_PHY),
        .PHY_BASIC_COUNT(T_PHY), .PROBE_COUNT(8)) rss_device_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .link(link), .eeprom_present_i(eeprom_present), .phy_link_i(phy_link), .chip_reset_o(chip_reset),
        .phy_reset_o(phy_reset), .mac_addr_reload_o(reload), .kept_across_soft_reset_o(kept),
        .soft_cleared_o(cleared));
    rss_host #(.TIMEOUT_COUNT(200)) rss_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
        .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .pin_reset_i(pin_reset));
    rss_props rss_props_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .hw_reset_pin_n(link.hw_reset_pin_n), .req(link.req), .wr(link.wr), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    function automatic logic [31:0] b1(input logic x);
        return {31'h0, x};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic hang(input string what);
        mismatches++;
        $display("CHECK FAILED at %0t: %s timed out", $time, what);
        close_out();
    endtask
    // One Avalon transfer; the request stands until waitrequest is seen low at a rising edge.
    task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) hang("bus transfer");
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic dev_op(input logic [2:0] cmd, input logic [2:0] a, input logic [31:0] d);
        int n;
        av_xfer(1'b1, HC_ADDR, {29'h0, a}, r);
        av_xfer(1'b1, HC_WDATA, d, r);
        av_xfer(1'b1, HC_CMD, {29'h0, cmd}, r);
        for (n = 0; n < 400; n++) begin
            av_xfer(1'b0, HC_STATUS, 32'h0000_0000, st);
            if (st[0] === 1'b0) break;
        end
        if (n == 400) hang("host command");
        av_xfer(1'b0, HC_RDATA, 32'h0000_0000, r);
    endtask
    task automatic rd_bit(input logic [2:0] a, input int unsigned b, input logic exp, input string what);
        dev_op(CMD_READ, a, 32'h0000_0000);
        check(b1(r[b]), b1(exp), what);
    endtask
    task automatic wait_ok(input logic [2:0] cmd, input logic to, input string what);
        dev_op(cmd, DEV_POWER_MGMT_CONTROL, 32'h0000_0000);
        check(st & 32'h0000_0006, {29'h0, to, !to, 1'b0}, what);
    endtask
    initial begin
        int i;
        logic [2:0] ra;
        int unsigned rb;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b0, "ready during power-on");
        check(b1(chip_reset), 32'h0000_0001, "chip reset held");
        wait_ok(CMD_WAIT_READY, 1'b0, "power-on wait");
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b1, "ready after power-on");
        check(b1(reload_seen), 32'h0000_0001, "reload started");
        wait_ok(CMD_WAIT_EEPROM, 1'b0, "probe wait");
        rd_bit(DEV_EEPROM_CMD, EEPROM_BUSY_BIT, 1'b0, "probe finished");
        dev_op(CMD_WRITE, DEV_HARDWARE_CONFIG, 32'h0000_00A0);
        dev_op(CMD_WRITE, DEV_EEPROM_CMD, 32'h0000_0055);
        check(cleared, 32'h0000_0055, "command written");
        dev_op(CMD_WRITE, DEV_HARDWARE_CONFIG, 32'h0000_00A1);
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b0, "ready during soft reset");
        rd_bit(DEV_HARDWARE_CONFIG, SOFT_RST_BIT, 1'b1, "soft bit while running");
        wait_ok(CMD_WAIT_READY, 1'b0, "soft reset wait");
        dev_op(CMD_READ, DEV_HARDWARE_CONFIG, 32'h0000_0000);
        check(r, 32'h0000_00A0, "config after soft reset");
        check(kept, 32'h0000_00A0, "kept bits");
        check(cleared, 32'h0000_0000, "command cleared");
        for (i = 0; i < 2; i++) begin
            ra = (i == 0) ? DEV_POWER_MGMT_CONTROL : DEV_PHY_BASIC;
            rb = (i == 0) ? PHY_RST_BIT : PHY_BASIC_RST_BIT;
            dev_op(CMD_WRITE, ra, 32'h0000_0001 << rb);
            check(b1(phy_reset), 32'h0000_0001, "phy reset running");
            rd_bit(ra, rb, 1'b1, "phy bit while running");
            repeat (128) @(posedge mclk_i);
            rd_bit(ra, rb, 1'b0, "phy bit cleared");
            check(b1(phy_reset), 32'h0000_0000, "phy reset ended");
        end
        wait_ok(CMD_WAIT_LINK, 1'b1, "link wait without link");
        phy_link <= 1'b1;
        wait_ok(CMD_WAIT_LINK, 1'b0, "link wait");
        dev_op(CMD_WRITE, DEV_POWER_MGMT_CONTROL, 32'h0000_1000);
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b0, "ready while asleep");
        wait_ok(CMD_WAIT_READY, 1'b1, "sleep wait times out");
        dev_op(CMD_WRITE, DEV_WAKE_TEST, 32'h0000_0000);
        wait_ok(CMD_WAIT_READY, 1'b0, "wake wait");
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b1, "ready after wake");
        pin_reset <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b0, "ready during pin reset");
        check(b1(chip_reset), 32'h0000_0001, "chip reset on pin");
        pin_reset <= 1'b0;
        wait_ok(CMD_WAIT_READY, 1'b0, "pin reset wait");
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b1, "ready after pin reset");
        av_xfer(1'b0, 4'hF, 32'h0000_0000, r);
        check(r, 32'h0000_0000, "unmapped address");
        eeprom_present <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_bit(DEV_POWER_MGMT_CONTROL, READY_BIT, 1'b0, "ready after power cycle");
        wait_ok(CMD_WAIT_READY, 1'b0, "second power-on wait");
        close_out();
    end
endmodule // test_reset_source_sequencer
